// file: design/dbag_pkg.sv
// Package of constants and types for the dual-bank acquisition gating block
package dbag_pkg;
   localparam int          CLK_MHZ        = 100;
   localparam int          DEAD_TIME_NS   = 800;
   localparam int          REARM_CYC      = (DEAD_TIME_NS * CLK_MHZ) / 1000;
   localparam int          PROC_MSPS      = 260;
   localparam int          BLK            = 4;
   localparam int          MAX_SEG_DUAL   = 8191;
   localparam int          MAX_SEG_SINGLE = 16384;
   localparam int          MAX_UGATES     = 4095;
   localparam int          MAX_TGATES     = 8192;
   localparam int          GAP_DUAL       = 32;
   localparam int          GAP_SINGLE     = 64;
   localparam int          MAX_PAD        = 16;
   localparam logic [0:0]  RST_BANK       = 1'h0;
   typedef enum logic [2:0] {
      DBAG_IDLE  = 3'b000,
      DBAG_ARMED = 3'b001,
      DBAG_DELAY = 3'b010,
      DBAG_CAPT  = 3'b011,
      DBAG_REARM = 3'b100,
      DBAG_DONE  = 3'b101
   } dbag_state_t;
endpackage : dbag_pkg

// file: design/dbag_core.sv
// Acquisition sequencer, bank control and threshold gate finder
`timescale 1ns/1ps
module dbag_core
   import dbag_pkg::*;
#(
   parameter int SW = 8,
   parameter int SEGW = 15,
   parameter int LENW = 24,
   parameter int DLYW = 24
) (
   input  wire logic            MCLK,
   input  wire logic            RST,
   input  wire logic            TRIG_IN,
   input  wire logic [SW-1:0]   SAMPLE,
   input  wire logic            RESYNC_MODE,
   input  wire logic            SINGLE_CH,
   input  wire logic            AUTOSWITCH,
   input  wire logic            AUTO_PROC,
   input  wire logic            PROC_ENABLE,
   input  wire logic            START_ACQ,
   input  wire logic            GRANT_NEXT,
   input  wire logic            SWITCH_BANK,
   input  wire logic            PROC_START,
   input  wire logic [SEGW-1:0] SEG_COUNT,
   input  wire logic [LENW-1:0] SEG_LEN,
   input  wire logic [DLYW-1:0] POST_TRIGGER_LAUNCH_DELAY,
   input  wire logic [SW-1:0]   THRESHOLD,
   input  wire logic            INVERT,
   input  wire logic [2:0]      PAD_SEL,
   input  wire logic            USE_TOTAL,
   input  wire logic [LENW-1:0] PRE_COUNT,
   input  wire logic [LENW-1:0] TOTAL_COUNT,
   input  wire logic            LIMIT_EN,
   input  wire logic [13:0]     LIMIT_M,
   output logic                 ACQ_READY,
   output logic                 TRIG_OUT,
   output logic                 WR_EN,
   output logic                 WR_BANK,
   output logic [LENW-1:0]      WR_ADDR,
   output logic [SW-1:0]        WR_DATA,
   output logic                 CYCLE_DONE,
   output logic                 PROC_BUSY,
   output logic                 PROC_DONE,
   output logic                 PROC_BANK,
   output logic                 GATE_VALID,
   output logic [LENW-1:0]      GATE_START,
   output logic [LENW-1:0]      GATE_LEN,
   output logic                 GATE_FULL
);
   if (SEGW < 15 || LENW < 8 || SW < 2) begin : g_bad_width
      $error("dbag_core: widths too small");
   end
   // ****************************************
   // Input synchronisers
   // ****************************************
   logic trig_s1, trig_s2, trig_s3;
   always_ff @(posedge MCLK) begin
      trig_s1 <= TRIG_IN;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
   end
   // Resync mode takes one extra stage to land on a fixed phase
   logic trig_rise;
   logic trig_sd;
   always_ff @(posedge MCLK) trig_sd <= trig_s3;
   assign trig_rise = RESYNC_MODE ? (trig_s3 & ~trig_sd) : (trig_s2 & ~trig_s3);
   // ****************************************
   // Sequencer
   // ****************************************
   dbag_state_t state, next_state;
   logic [SEGW-1:0] seg, next_seg;
   logic [LENW-1:0] smp, next_smp;
   logic [DLYW-1:0] dly, next_dly;
   logic [7:0]      rearm, next_rearm;
   logic            bank, next_bank, grant, next_grant, done_p, next_done_p;
   logic [SEGW-1:0] seg_lim;
   assign seg_lim = (SEG_COUNT == '0) ? SEGW'(1) :
                    (!SINGLE_CH && SEG_COUNT > SEGW'(MAX_SEG_DUAL)) ? SEGW'(MAX_SEG_DUAL) :
                    (SEG_COUNT > SEGW'(MAX_SEG_SINGLE)) ? SEGW'(MAX_SEG_SINGLE) : SEG_COUNT;
   always_comb begin
      next_state  = state;
      next_seg    = seg;
      next_smp    = smp;
      next_dly    = dly;
      next_rearm  = rearm;
      next_bank   = bank;
      next_grant  = grant | GRANT_NEXT;
      next_done_p = 1'b0;
      if (SWITCH_BANK && state == DBAG_IDLE) next_bank = ~bank;
      unique case (state)
         DBAG_IDLE: begin
            if (START_ACQ) begin
               next_state = DBAG_ARMED;
               next_seg   = '0;
            end
         end
         DBAG_ARMED: begin
            if (trig_rise) begin
               next_state = DBAG_DELAY;
               next_dly   = POST_TRIGGER_LAUNCH_DELAY;
            end
         end
         DBAG_DELAY: begin
            if (dly == '0) begin
               next_state = DBAG_CAPT;
               next_smp   = '0;
            end else next_dly = dly - 1'b1;
         end
         DBAG_CAPT: begin
            next_smp = smp + 1'b1;
            if (smp == SEG_LEN - 1'b1) begin
               next_seg = seg + 1'b1;
               if (seg + 1'b1 == seg_lim) begin
                  next_state  = DBAG_DONE;
                  next_done_p = 1'b1;
               end else begin
                  next_state = DBAG_REARM;
                  next_rearm = 8'(REARM_CYC - 2);
               end
            end
         end
         DBAG_REARM: begin
            // Rearm takes 79 cycles, just inside the 80-cycle dead-time budget
            if (rearm == '0) next_state = DBAG_ARMED;
            else next_rearm = rearm - 1'b1;
         end
         DBAG_DONE: begin
            if (AUTOSWITCH && grant) begin
               next_state = DBAG_ARMED;
               next_bank  = ~bank;
               next_seg   = '0;
               next_grant = GRANT_NEXT;
            end else if (!AUTOSWITCH || START_ACQ) begin
               next_state = AUTOSWITCH ? DBAG_DONE : DBAG_IDLE;
            end
         end
         default: next_state = DBAG_IDLE;
      endcase
   end
   always_ff @(posedge MCLK) begin
      if (RST) begin
         state  <= DBAG_IDLE;
         seg    <= '0;
         smp    <= '0;
         dly    <= '0;
         rearm  <= '0;
         bank   <= RST_BANK;
         grant  <= 1'b0;
         done_p <= 1'b0;
      end else begin
         state  <= next_state;
         seg    <= next_seg;
         smp    <= next_smp;
         dly    <= next_dly;
         rearm  <= next_rearm;
         bank   <= next_bank;
         grant  <= next_grant;
         done_p <= next_done_p;
      end
   end
   // ****************************************
   // Write port and status
   // ****************************************
   always_ff @(posedge MCLK) begin
      if (RST) begin
         WR_EN    <= 1'b0;
         WR_BANK  <= RST_BANK;
         WR_ADDR  <= '0;
         WR_DATA  <= '0;
         TRIG_OUT <= 1'b0;
      end else begin
         WR_EN    <= (state == DBAG_CAPT);
         WR_BANK  <= bank;
         WR_ADDR  <= LENW'(seg * SEG_LEN) + smp;
         WR_DATA  <= SAMPLE;
         TRIG_OUT <= (state == DBAG_ARMED) && trig_rise;
      end
   end
   assign ACQ_READY  = (state == DBAG_ARMED);
   assign CYCLE_DONE = done_p;
   // ****************************************
   // Processing control
   // ****************************************
   logic busy, next_busy, pdone, next_pdone, pbank, next_pbank;
   logic [LENW-1:0] pcnt, next_pcnt;
   always_comb begin
      next_busy  = busy;
      next_pdone = 1'b0;
      next_pbank = pbank;
      next_pcnt  = pcnt;
      if (!busy && ((AUTO_PROC && done_p) || (!AUTO_PROC && PROC_START))) begin
         next_pbank = AUTO_PROC ? bank : ~bank;
         if (!PROC_ENABLE) next_pdone = 1'b1;
         else begin
            next_busy = 1'b1;
            next_pcnt = LENW'(seg_lim * SEG_LEN);
         end
      end else if (busy) begin
         // One sample per clock is 100 MS/s at 100 MHz, below the 260 MS/s budget
         if (pcnt <= LENW'(1)) begin
            next_busy  = 1'b0;
            next_pdone = 1'b1;
         end else next_pcnt = pcnt - 1'b1;
      end
   end
   always_ff @(posedge MCLK) begin
      if (RST) begin
         busy  <= 1'b0;
         pdone <= 1'b0;
         pbank <= RST_BANK;
         pcnt  <= '0;
      end else begin
         busy  <= next_busy;
         pdone <= next_pdone;
         pbank <= next_pbank;
         pcnt  <= next_pcnt;
      end
   end
   assign PROC_BUSY = busy;
   assign PROC_DONE = pdone;
   assign PROC_BANK = pbank;
   // ****************************************
   // Threshold gate finder
   // ****************************************
   logic hot;
   assign hot = INVERT ? (SAMPLE < THRESHOLD) : (SAMPLE > THRESHOLD);
   logic            blk_hot, in_reg, gv;
   logic [LENW-1:0] r_start, r_end, cold, gs, gl;
   logic [13:0]     seg_gates, acq_gates;
   logic            held, gfull;
   logic [LENW-1:0] pad, gap_need;
   assign pad      = LENW'({PAD_SEL > 3'h4 ? 3'h4 : PAD_SEL, 2'b00});
   assign gap_need = SINGLE_CH ? LENW'(GAP_SINGLE) : LENW'(GAP_DUAL);
   logic cap, blk_end, blk_first, gap_ok, seg_last;
   assign cap       = (state == DBAG_CAPT);
   assign blk_end   = smp[1:0] == 2'h3;
   assign blk_first = smp[1:0] == 2'h0;
   assign seg_last  = cap && (smp == SEG_LEN - 1'b1);
   // Cold run counted per sample since the last hot one, plus a margin of 15 (dual) or 31 (single)
   assign gap_ok    = cold >= gap_need + (SINGLE_CH ? LENW'(31) : LENW'(15));
   logic emit, lim_drop;
   assign emit     = in_reg && ((cap && blk_first && !blk_hot && gap_ok) || seg_last);
   assign lim_drop = LIMIT_EN && (seg_gates + 1'b1 >= LIMIT_M) && !seg_last;
   always_ff @(posedge MCLK) begin
      if (RST || !cap && state == DBAG_IDLE) begin
         blk_hot <= 1'b0;
         in_reg <= 1'b0;
         r_start <= '0;
         r_end <= '0;
         cold <= '0;
         gv <= 1'b0;
         gs <= '0;
         gl <= '0;
         seg_gates <= '0;
         acq_gates <= '0;
         held <= 1'b0;
         gfull <= 1'b0;
      end else begin
         gv <= 1'b0;
         if (cap) begin
            blk_hot <= blk_first ? hot : (blk_hot | hot);
            cold <= hot ? '0 : cold + 1'b1;
            if (blk_end && (blk_hot | hot)) begin
               if (!in_reg) r_start <= {smp[LENW-1:2], 2'b00};
               in_reg <= 1'b1;
               r_end <= smp + 1'b1;
            end
            if (emit && acq_gates < 14'(MAX_TGATES)) begin
               gv <= !lim_drop;
               gs <= USE_TOTAL ? r_start - PRE_COUNT : (r_start > pad ? r_start - pad : '0);
               gl <= USE_TOTAL ? TOTAL_COUNT : r_end - r_start + (pad << 1);
               in_reg <= 1'b0;
               if (!lim_drop) acq_gates <= acq_gates + 1'b1;
               seg_gates <= seg_last ? '0 : seg_gates + 1'b1;
            end else if (seg_last) seg_gates <= '0;
         end
         gfull <= (acq_gates == 14'(MAX_TGATES));
      end
   end
   assign GATE_VALID = gv;
   assign GATE_START = gs;
   assign GATE_LEN   = gl;
   assign GATE_FULL  = gfull;
   // ****************************************
   // Checks
   // ****************************************
   chk_seg_bank: assert property (@(posedge MCLK) disable iff (RST)
      (state == DBAG_CAPT && $past(state) == DBAG_CAPT) |-> $stable(bank))
      else $error("bank changed during capture");
   chk_stop_write: assert property (@(posedge MCLK) disable iff (RST)
      done_p |=> !WR_EN)
      else $error("write after cycle end");
   chk_rearm_time: assert property (@(posedge MCLK) disable iff (RST)
      (state == DBAG_REARM && $past(state) == DBAG_CAPT) |-> ##[1:79] state == DBAG_ARMED)
      else $error("rearm too slow");
   chk_auto_switch: assert property (@(posedge MCLK) disable iff (RST)
      (state == DBAG_DONE && AUTOSWITCH && grant) |=> (state == DBAG_ARMED && bank != $past(bank)))
      else $error("autoswitch did not restart");
   chk_null_proc: assert property (@(posedge MCLK) disable iff (RST)
      (!busy && !AUTO_PROC && PROC_START && !PROC_ENABLE) |=> pdone && !busy)
      else $error("null processing not immediate");
   chk_gate_align: assert property (@(posedge MCLK) disable iff (RST)
      gv && !USE_TOTAL |-> gs[1:0] == 2'h0 && gl[1:0] == 2'h0)
      else $error("gate not block aligned");
   chk_gate_cap: assert property (@(posedge MCLK) disable iff (RST)
      acq_gates <= 14'(MAX_TGATES))
      else $error("gate count overflow");
   chk_trig_out: assert property (@(posedge MCLK) disable iff (RST)
      TRIG_OUT |-> $past(state) == DBAG_ARMED)
      else $error("trigger out while not armed");
   chk_first_seg: assert property (@(posedge MCLK) disable iff (RST)
      (state == DBAG_IDLE && START_ACQ) |=> seg == '0)
      else $error("segment count not cleared");
   cov_single: cover property (@(posedge MCLK) done_p && seg_lim == SEGW'(1));
   cov_auto: cover property (@(posedge MCLK) state == DBAG_DONE && AUTOSWITCH && grant);
   cov_gate: cover property (@(posedge MCLK) gv);
   cov_proc: cover property (@(posedge MCLK) busy ##1 pdone);
endmodule : dbag_core

// file: dv/dbag_host.sv
// Host software model issuing command pulses to the core
`timescale 1ns/1ps
module dbag_host (
   input  wire logic MCLK,
   output logic      START_ACQ,
   output logic      GRANT_NEXT,
   output logic      SWITCH_BANK,
   output logic      PROC_START
);
   // ****************************************
   // Command pulses, one cycle, off the falling edge
   // ****************************************
   initial {START_ACQ, GRANT_NEXT, SWITCH_BANK, PROC_START} = 4'h0;
   task automatic send(input logic [3:0] m);
      @(negedge MCLK);
      {START_ACQ, GRANT_NEXT, SWITCH_BANK, PROC_START} <= m;
      @(negedge MCLK);
      {START_ACQ, GRANT_NEXT, SWITCH_BANK, PROC_START} <= 4'h0;
   endtask : send
   // Launch, then grant the follow-on acquisition at once
   task automatic start_auto();
      send(4'h8);
      send(4'h4);
   endtask : start_auto
   // Other bank, restart, then process the old bank
   task automatic turnover();
      send(4'h2);
      send(4'h8);
      send(4'h1);
   endtask : turnover
endmodule : dbag_host

// file: dv/dbag_bench.sv
// Self-checking bench for the dual-bank acquisition gating core
`timescale 1ns/1ps
module dbag_bench;
   import dbag_pkg::*;
   typedef struct packed {logic [23:0] s; logic [23:0] l;} dbag_gate_t;
   // ****************************************
   // Stimulus and observation signals
   // ****************************************
   logic        MCLK = 1'b0, RST = 1'b1, TRIG_IN = 1'b0, RESYNC_MODE = 1'b0, SINGLE_CH = 1'b0;
   logic        AUTOSWITCH = 1'b0, AUTO_PROC = 1'b0, PROC_ENABLE = 1'b0, INVERT = 1'b0;
   logic        USE_TOTAL = 1'b0, LIMIT_EN = 1'b0;
   logic [7:0]  SAMPLE = 8'h00, THRESHOLD = 8'h80;
   logic [14:0] SEG_COUNT = 15'h3;
   logic [23:0] SEG_LEN = 24'h10, POST_TRIGGER_LAUNCH_DELAY = 24'h3;
   logic [23:0] PRE_COUNT = 24'h0, TOTAL_COUNT = 24'h0;
   logic [2:0]  PAD_SEL = 3'h0;
   logic [13:0] LIMIT_M = 14'h4;
   logic        START_ACQ, GRANT_NEXT, SWITCH_BANK, PROC_START, ACQ_READY, TRIG_OUT, WR_EN;
   logic        WR_BANK, CYCLE_DONE, PROC_BUSY, PROC_DONE, PROC_BANK, GATE_VALID, GATE_FULL;
   logic [23:0] WR_ADDR, GATE_START, GATE_LEN;
   logic [7:0]  WR_DATA;
   logic [0:0]  exp_bank = 1'h0;
   int          num_errors = 0, n_compared = 0, n_wr = 0, idx = 0, ha = -100, hb = -100;
   dbag_gate_t  gq[$];
   dbag_gate_t  g;
   always #5 MCLK = ~MCLK;
   dbag_core dut_u (.MCLK, .RST, .TRIG_IN, .SAMPLE, .RESYNC_MODE, .SINGLE_CH, .AUTOSWITCH,
      .AUTO_PROC, .PROC_ENABLE, .START_ACQ, .GRANT_NEXT, .SWITCH_BANK, .PROC_START,
      .SEG_COUNT, .SEG_LEN, .POST_TRIGGER_LAUNCH_DELAY, .THRESHOLD, .INVERT, .PAD_SEL,
      .USE_TOTAL, .PRE_COUNT, .TOTAL_COUNT, .LIMIT_EN, .LIMIT_M, .ACQ_READY, .TRIG_OUT,
      .WR_EN, .WR_BANK, .WR_ADDR, .WR_DATA, .CYCLE_DONE, .PROC_BUSY, .PROC_DONE, .PROC_BANK,
      .GATE_VALID, .GATE_START, .GATE_LEN, .GATE_FULL);
   dbag_host host_u (.MCLK, .START_ACQ, .GRANT_NEXT, .SWITCH_BANK, .PROC_START);
   // ****************************************
   // Checking helpers
   // ****************************************
   task automatic chk(input logic good, input string m);
      n_compared++;
      if (good !== 1'b1) begin
         $display("[ERR] %0t %s", $time, m);
         num_errors++;
      end
   endtask : chk
   task automatic report_and_stop();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   // Sel: 0 ready, 1 trigger out, 2 cycle done, 3 processing done
   task automatic waitsig(input int sel, input int lim, output int n);
      logic v;
      for (n = 0; n < lim; n++) begin
         @(negedge MCLK);
         v = sel == 0 ? ACQ_READY : sel == 1 ? TRIG_OUT : sel == 2 ? CYCLE_DONE : PROC_DONE;
         if (v === 1'b1) return;
      end
      chk(1'b0, "wait ran out");
      report_and_stop();
   endtask : waitsig
   function automatic logic is_hot(input int i);
      return i == ha || i == ha + 1 || i == hb || i == hb + 1;
   endfunction : is_hot
   // ****************************************
   // Sample source and output watchers
   // ****************************************
   always @(negedge MCLK) begin
      idx <= TRIG_OUT === 1'b1 ? 0 : idx + 1;
      SAMPLE <= (is_hot(TRIG_OUT === 1'b1 ? 0 : idx + 1) ^ INVERT) ?
                8'h90 + 8'($urandom % 96) : 8'($urandom % 112);
   end
   always @(negedge MCLK) begin
      if (!RST && WR_EN === 1'b1) begin
         n_wr <= n_wr + 1;
         chk(WR_BANK === exp_bank, "write went to the wrong bank");
         chk(WR_ADDR === 24'(n_wr), "write address out of sequence");
         chk(WR_DATA === SAMPLE, "written data differs from sample");
      end
      if (!RST && GATE_VALID === 1'b1) begin
         chk(GATE_START[1:0] === 2'h0 && GATE_LEN[1:0] === 2'h0, "gate not block aligned");
         chk(gq.size() > 0, "unexpected gate");
         if (gq.size() > 0) begin
            g = gq.pop_front();
            chk(GATE_START === g.s && GATE_LEN === g.l, "gate position or length");
         end
      end
   end
   // One buffered sequence of nseg triggers into the given bank
   task automatic acq(input int nseg, input logic [0:0] bank);
      int n;
      int lim;
      lim = int'(SEG_LEN) + int'(POST_TRIGGER_LAUNCH_DELAY) + REARM_CYC + 8;
      exp_bank = bank;
      n_wr = 0;
      for (int s = 0; s < nseg; s++) begin
         waitsig(0, lim, n);
         TRIG_IN <= 1'b1;
         waitsig(1, 8, n);
         chk(n == 2 + int'(RESYNC_MODE), "trigger output latency");
         TRIG_IN <= 1'b0;
      end
      waitsig(2, lim, n);
      repeat (3) @(negedge MCLK);
      chk(n_wr == nseg * int'(SEG_LEN), "written sample count");
   endtask : acq
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      int n;
      void'($urandom(63));
      POST_TRIGGER_LAUNCH_DELAY <= 24'($urandom % 8);
      repeat (20) @(negedge MCLK);
      chk(WR_EN === 1'b0 && CYCLE_DONE === 1'b0 && GATE_VALID === 1'b0 && WR_BANK === 1'b0,
          "outputs not idle in reset");
      RST <= 1'b0;
      host_u.send(4'h8);
      acq(3, 1'h0);
      SEG_COUNT <= 15'h0;
      RESYNC_MODE <= 1'b1;
      POST_TRIGGER_LAUNCH_DELAY <= 24'h0;
      host_u.turnover();
      chk(PROC_DONE === 1'b1 && PROC_BUSY === 1'b0, "null processing not immediate");
      chk(PROC_BANK === 1'b0, "manual processing bank");
      acq(1, 1'h1);
      SEG_LEN <= 24'h80;
      SEG_COUNT <= 15'h1;
      PRE_COUNT <= 24'h8;
      TOTAL_COUNT <= 24'h20;
      LIMIT_M <= 14'h1;
      for (int i = 0; i < 10; i++) begin
         PAD_SEL <= i < 5 ? 3'(i) : 3'h0;
         INVERT <= i[0] && i < 5;
         SINGLE_CH <= i == 7;
         USE_TOTAL <= i == 8;
         LIMIT_EN <= i == 9;
         ha = 21;
         hb = (i < 5 || i == 8) ? -100 : i == 5 ? 40 : 90;
         if (i < 5)
            gq.push_back({24'(20 - 4 * i), 24'(4 + 8 * i)});
         else if (i == 5)
            gq.push_back({24'h14, 24'h18});
         else if (i == 6) begin
            gq.push_back({24'h14, 24'h4});
            gq.push_back({24'h58, 24'h4});
         end else if (i == 7)
            gq.push_back({24'h14, 24'h48});
         else if (i == 8)
            gq.push_back({24'h0c, 24'h20});
         else
            gq.push_back({24'h58, 24'h4});
         host_u.send(4'h8);
         acq(1, 1'h1);
         for (n = 0; n < 200 && gq.size() > 0; n++) @(negedge MCLK);
         chk(gq.size() == 0, "missing gate");
      end
      ha = -100;
      hb = -100;
      LIMIT_EN <= 1'b0;
      SEG_LEN <= 24'h10;
      SEG_COUNT <= 15'h2;
      AUTOSWITCH <= 1'b1;
      AUTO_PROC <= 1'b1;
      PROC_ENABLE <= 1'b1;
      host_u.start_auto();
      acq(2, 1'h1);
      chk(ACQ_READY === 1'b1 && PROC_BANK === 1'b1 && PROC_BUSY === 1'b1,
          "no turnover to other bank");
      waitsig(3, 40, n);
      chk(PROC_BANK === 1'b1, "automatic processing bank");
      acq(2, 1'h0);
      chk(GATE_FULL === 1'b0, "gate limit flagged too early");
      report_and_stop();
   end
   initial begin
      #900000;
      chk(1'b0, "run did not finish");
      report_and_stop();
   end
endmodule : dbag_bench
